//--- inc/motion_irq_pkg.sv
package motion_irq_pkg;

  // ----------------
  // register offsets
  // ----------------
  localparam logic [7:0] ADDR_LIVE_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_STATUS_ALIAS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h06;
  localparam logic [7:0] ADDR_MOTION_CTRL = 8'h09;
  localparam logic [7:0] ADDR_QUEUE_FLAGS = 8'h0a;
  localparam logic [7:0] ADDR_LIVE_MIRROR = 8'h13;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_QUEUE_CTRL = 8'h2d;
  localparam logic [7:0] ADDR_QUEUE_THRESH = 8'h2e;
  localparam logic [7:0] ADDR_QUEUE_STATUS = 8'h2f;
  localparam logic [7:0] ADDR_IRQ_CONFIG = 8'h31;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h33;
  localparam logic [7:0] ADDR_LATCH_TIMER = 8'h4a;

  // ----------------
  // field positions
  // ----------------
  // motion sources, same bit in live flags, status and enable
  localparam int MOT_TILT = 0;
  localparam int MOT_FLIP = 1;
  localparam int MOT_MOVE = 2;
  localparam int MOT_SHAKE = 3;
  localparam int MOT_TILT35 = 4;
  localparam int MOTION_COUNT = 5;
  localparam int ST_QUEUE = 5;
  localparam int ST_SAMPLE = 7;
  // motion feature control
  localparam int FEAT_TILTFLIP = 0;
  localparam int FEAT_MOVE = 2;
  localparam int FEAT_SHAKE = 3;
  localparam int FEAT_TILT35 = 4;
  // queue flags, queue status and queue control enables
  localparam int Q_EMPTY = 0;
  localparam int Q_FULL = 1;
  localparam int Q_LEVEL = 2;
  localparam int Q_ENABLE = 5;
  // interrupt configuration
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_COMBINE = 3;
  localparam int CFG_COMBINE_PIN = 4;
  localparam int CFG_SWAP = 5;
  localparam int CFG_PER_BIT_CLEAR = 6;
  // pin control: drive 1 = push-pull, polarity 1 = active high
  localparam int PIN_A_DRIVE = 2;
  localparam int PIN_A_POLARITY = 3;
  localparam int PIN_B_DRIVE = 6;
  localparam int PIN_B_POLARITY = 7;

  // ----------------
  // reset values
  // ----------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_QUEUE_THRESH = 8'h10;
  localparam logic [2:0] RST_QUEUE_FLAGS = 3'h1;

  // ----------------
  // modes and timing
  // ----------------
  typedef enum logic [1:0] {
    MODE_LATCHED = 2'b00,
    MODE_TIMED = 2'b01,
    MODE_AUTO = 2'b10
  } irq_mode_type;

  localparam int QUEUE_DEPTH = 32;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LATCH_UNIT_NS = 1000000;
  localparam int LATCH_UNIT_CYCLES = (LATCH_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : motion_irq_pkg

//--- inc/latch_timer_if.sv
`timescale 1ns/1ps

// ----------------
// link between the interrupt unit and its timed-latch timer
// ----------------
interface latch_timer_if;
  logic run;
  logic [7:0] periodUnits;
  logic expired;

  modport owner (output run, output periodUnits, input expired);
  modport timer (input run, input periodUnits, output expired);
endinterface : latch_timer_if

//--- design/latch_timer.sv
`timescale 1ns/1ps

// ----------------
// timed-latch timer: expires (periodUnits+1) units after run rises
// ----------------
module latch_timer #(
  parameter int UNIT_CYCLES = motion_irq_pkg::LATCH_UNIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  latch_timer_if.timer tif
);

  localparam int PRESC_W = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(UNIT_CYCLES - 1);

  logic [PRESC_W-1:0] presc_q;
  logic [7:0] units_q;
  logic expired_q;
  logic unitWrap;

  assign unitWrap = (presc_q == PRESC_LAST);
  assign tif.expired = expired_q;

  // prescaler and unit counter, held at zero while not running
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      presc_q <= '0;
      units_q <= 8'h00;
    end
    else if (!tif.run)
    begin
      presc_q <= '0;
      units_q <= 8'h00;
    end
    else if (unitWrap)
    begin
      presc_q <= '0;
      units_q <= (units_q == tif.periodUnits) ? 8'h00 : units_q + 8'h01;
    end
    else
    begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  // one-cycle expiry pulse at the end of the last unit
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      expired_q <= 1'b0;
    else
      expired_q <= tif.run && unitWrap && (units_q == tif.periodUnits);
  end

endmodule : latch_timer

//--- design/motion_sensor_interrupt_unit.sv
`timescale 1ns/1ps

// Overview of operation
// - motion events pass their enable bit before setting status, sample flag does not; queue enables in queue control
// - sample and motion status in one register, queue status in another
// - in global mode each status write clears pending interrupts and re-arms them
// - each pin has its own polarity and drive select bits
// - sample flag sets once per sample and clears when software reads it
// - a sample raises a request only while its enable bit is set
// - tilt and flip share one feature enable, keep separate interrupt enables
// - movement flag needs its feature enable; status at bit 2
// - shake needs its feature and movement feature, not movement interrupt enable
// - tilt35 needs its feature and movement feature; status at bit 4
// - queue empty gated by queue enable, reads one after reset
// - queue full gated by queue enable, reads zero after reset, enable bit 1
// - queue level flag zero after reset, threshold default sixteen
// - queue interrupts need only queue control enables
// - latched, timed-latch and auto-clear modes
// - queue interrupts always behave latched
// - global clearing when per-bit clear select is zero
// - global: any write to either status address clears all pending interrupts but not the sample flag, data ignored
// - per-bit: main status writes clear ones; bit 5 clears all queue flags
// - auto-clear: sample at z accumulation start, motion when condition ends
// - reset routing: sample+motion to pin a, queue to pin b, open-drain low
module motion_sensor_interrupt_unit #(
  parameter int UNIT_CYCLES = motion_irq_pkg::LATCH_UNIT_CYCLES,
  parameter int QUEUE_DEPTH = motion_irq_pkg::QUEUE_DEPTH,
  parameter int COUNT_W = $clog2(QUEUE_DEPTH + 1)
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic softwareReset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic sampleDone,
  input wire logic zAccumStart,
  input wire logic [4:0] motionLive,
  input wire logic [COUNT_W-1:0] queueCount,
  output logic irqPinAOut,
  output logic irqPinAOe,
  output logic irqPinBOut,
  output logic irqPinBOe
);

  localparam int NM = motion_irq_pkg::MOTION_COUNT;
  localparam logic [COUNT_W-1:0] COUNT_FULL = COUNT_W'(QUEUE_DEPTH);

  // ----------------
  // helpers
  // ----------------
  // write strobe for one register offset
  function automatic logic wrHit(input logic en, input logic [7:0] addr, input logic [7:0] target);
    wrHit = en && (addr == target);
  endfunction : wrHit

  // pin level and enable from request, polarity and drive selects
  function automatic logic [1:0] pinDrive(input logic req, input logic activeHigh, input logic pushPull);
    logic level;
    level = activeHigh ? req : ~req;
    pinDrive = pushPull ? {level, 1'b1} : {1'b0, ~level};
  endfunction : pinDrive

  // ----------------
  // declarations
  // ----------------
  logic [7:0] irqEnable_q;
  logic [7:0] motionCtrl_q;
  logic [7:0] queueCtrl_q;
  logic [7:0] queueThresh_q;
  logic [7:0] irqConfig_q;
  logic [7:0] pinCtrl_q;
  logic [7:0] latchTimer_q;
  logic [NM-1:0] featOn;
  logic [NM-1:0] motionGated;
  logic [NM-1:0] motionPrev_q;
  logic [NM-1:0] motionPend_q;
  logic [NM-1:0] motionClr;
  logic sampleFlag_q;
  logic sampleIrq_q;
  logic [2:0] queueFlags_q;
  logic [2:0] queueFlagsNow;
  logic [2:0] queueGated;
  logic [2:0] queuePrev_q;
  logic [2:0] queuePend_q;
  logic [7:0] clrVec;
  logic wrStatus;
  logic wrAlias;
  logic rdStatus;
  logic globalMode;
  logic modeTimed;
  logic modeAuto;
  logic timedClr;
  logic sampleMotionReq;
  logic queueReq;
  logic reqA;
  logic reqB;
  logic [1:0] driveA;
  logic [1:0] driveB;
  logic [7:0] statusView;
  logic [7:0] rdData_d;
  logic [7:0] rdData_q;
  logic pinAOut_q;
  logic pinAOe_q;
  logic pinBOut_q;
  logic pinBOe_q;
  motion_irq_pkg::irq_mode_type mode;

  latch_timer_if timerBus ();

  // ----------------
  // control registers
  // ----------------
  // software-written configuration, restored on either reset
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqEnable_q <= motion_irq_pkg::RST_REG;
      motionCtrl_q <= motion_irq_pkg::RST_REG;
      queueCtrl_q <= motion_irq_pkg::RST_REG;
      queueThresh_q <= motion_irq_pkg::RST_QUEUE_THRESH;
      irqConfig_q <= motion_irq_pkg::RST_REG;
      pinCtrl_q <= motion_irq_pkg::RST_REG;
      latchTimer_q <= motion_irq_pkg::RST_REG;
    end
    else if (softwareReset)
    begin
      irqEnable_q <= motion_irq_pkg::RST_REG;
      motionCtrl_q <= motion_irq_pkg::RST_REG;
      queueCtrl_q <= motion_irq_pkg::RST_REG;
      queueThresh_q <= motion_irq_pkg::RST_QUEUE_THRESH;
      irqConfig_q <= motion_irq_pkg::RST_REG;
      pinCtrl_q <= motion_irq_pkg::RST_REG;
      latchTimer_q <= motion_irq_pkg::RST_REG;
    end
    else if (regWrEn)
    begin
      if (regAddr == motion_irq_pkg::ADDR_IRQ_ENABLE)
        irqEnable_q <= regWrData;
      else if (regAddr == motion_irq_pkg::ADDR_MOTION_CTRL)
        motionCtrl_q <= regWrData;
      else if (regAddr == motion_irq_pkg::ADDR_QUEUE_CTRL)
        queueCtrl_q <= regWrData;
      else if (regAddr == motion_irq_pkg::ADDR_QUEUE_THRESH)
        queueThresh_q <= regWrData;
      else if (regAddr == motion_irq_pkg::ADDR_IRQ_CONFIG)
        irqConfig_q <= regWrData;
      else if (regAddr == motion_irq_pkg::ADDR_PIN_CTRL)
        pinCtrl_q <= regWrData;
      else if (regAddr == motion_irq_pkg::ADDR_LATCH_TIMER)
        latchTimer_q <= regWrData;
    end
  end

  // ----------------
  // mode and clear decode
  // ----------------
  // reserved mode code behaves as latched
  always_comb
  begin
    case (irqConfig_q[motion_irq_pkg::CFG_MODE_LSB +: 2])
      2'b01: mode = motion_irq_pkg::MODE_TIMED;
      2'b10: mode = motion_irq_pkg::MODE_AUTO;
      default: mode = motion_irq_pkg::MODE_LATCHED;
    endcase
  end

  assign modeTimed = (mode == motion_irq_pkg::MODE_TIMED);
  assign modeAuto = (mode == motion_irq_pkg::MODE_AUTO);
  assign globalMode = ~irqConfig_q[motion_irq_pkg::CFG_PER_BIT_CLEAR];
  assign wrStatus = wrHit(regWrEn, regAddr, motion_irq_pkg::ADDR_STATUS);
  assign wrAlias = wrHit(regWrEn, regAddr, motion_irq_pkg::ADDR_STATUS_ALIAS);
  assign rdStatus = regRdEn && ((regAddr == motion_irq_pkg::ADDR_STATUS)
                                || (regAddr == motion_irq_pkg::ADDR_STATUS_ALIAS));

  // software clear vector, one bit per status position
  always_comb
  begin
    if (globalMode)
      clrVec = (wrStatus || wrAlias) ? 8'hff : 8'h00;
    else
      clrVec = wrStatus ? regWrData : 8'h00;
  end

  // ----------------
  // sample-ready flag and request
  // ----------------
  // flag always tracks samples; read clears it, a new sample wins
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sampleFlag_q <= 1'b0;
    else if (softwareReset)
      sampleFlag_q <= 1'b0;
    else if (sampleDone)
      sampleFlag_q <= 1'b1;
    else if (rdStatus)
      sampleFlag_q <= 1'b0;
  end

  // pending request only while enabled; set wins over every clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sampleIrq_q <= 1'b0;
    else if (softwareReset)
      sampleIrq_q <= 1'b0;
    else if (sampleDone && irqEnable_q[motion_irq_pkg::ST_SAMPLE])
      sampleIrq_q <= 1'b1;
    else if (clrVec[motion_irq_pkg::ST_SAMPLE] || timedClr || (modeAuto && zAccumStart))
      sampleIrq_q <= 1'b0;
  end

  // ----------------
  // motion flags
  // ----------------
  // feature gating of the live flags
  assign featOn[motion_irq_pkg::MOT_TILT] = motionCtrl_q[motion_irq_pkg::FEAT_TILTFLIP];
  assign featOn[motion_irq_pkg::MOT_FLIP] = motionCtrl_q[motion_irq_pkg::FEAT_TILTFLIP];
  assign featOn[motion_irq_pkg::MOT_MOVE] = motionCtrl_q[motion_irq_pkg::FEAT_MOVE];
  assign featOn[motion_irq_pkg::MOT_SHAKE] = motionCtrl_q[motion_irq_pkg::FEAT_SHAKE]
                                             & motionCtrl_q[motion_irq_pkg::FEAT_MOVE];
  assign featOn[motion_irq_pkg::MOT_TILT35] = motionCtrl_q[motion_irq_pkg::FEAT_TILT35]
                                              & motionCtrl_q[motion_irq_pkg::FEAT_MOVE];
  assign motionGated = motionLive & featOn;

  // edge history of the gated flags
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      motionPrev_q <= '0;
    else if (softwareReset)
      motionPrev_q <= '0;
    else
      motionPrev_q <= motionGated;
  end

  // one latched status bit per source, each with its own enable
  generate
    for (genvar i = 0; i < NM; i++)
    begin : gMotion
      assign motionClr[i] = clrVec[i] || timedClr || (modeAuto && !motionGated[i]);
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          motionPend_q[i] <= 1'b0;
        else if (softwareReset)
          motionPend_q[i] <= 1'b0;
        else if (motionGated[i] && !motionPrev_q[i] && irqEnable_q[i])
          motionPend_q[i] <= 1'b1;
        else if (motionClr[i])
          motionPend_q[i] <= 1'b0;
      end
    end
  endgenerate

  // ----------------
  // queue flags
  // ----------------
  // live queue flags derived from the sample count
  assign queueFlagsNow[motion_irq_pkg::Q_EMPTY] = (queueCount == '0);
  assign queueFlagsNow[motion_irq_pkg::Q_FULL] = (queueCount == COUNT_FULL);
  assign queueFlagsNow[motion_irq_pkg::Q_LEVEL] = ({{(8 - COUNT_W){1'b0}}, queueCount} >= queueThresh_q);
  assign queueGated = queueFlags_q & {3{queueCtrl_q[motion_irq_pkg::Q_ENABLE]}};

  // flag snapshot: empty reads one after either reset
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      queueFlags_q <= motion_irq_pkg::RST_QUEUE_FLAGS;
      queuePrev_q <= 3'h0;
    end
    else if (softwareReset)
    begin
      queueFlags_q <= motion_irq_pkg::RST_QUEUE_FLAGS;
      queuePrev_q <= 3'h0;
    end
    else
    begin
      queueFlags_q <= queueFlagsNow;
      queuePrev_q <= queueGated;
    end
  end

  // queue status: own enables only, cleared only by software
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      queuePend_q <= 3'h0;
    else if (softwareReset)
      queuePend_q <= 3'h0;
    else
      queuePend_q <= (queuePend_q & ~{3{clrVec[motion_irq_pkg::ST_QUEUE]}})
                     | (queueGated & ~queuePrev_q & queueCtrl_q[2:0]);
  end

  // ----------------
  // timed latch
  // ----------------
  assign timerBus.run = modeTimed && ((|motionPend_q) || sampleIrq_q);
  assign timerBus.periodUnits = latchTimer_q;
  assign timedClr = modeTimed && timerBus.expired;

  latch_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) uTimer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tif(timerBus.timer)
  );

  // ----------------
  // requests and pins
  // ----------------
  // requests are the OR of enabled pending bits
  assign sampleMotionReq = (|(motionPend_q & irqEnable_q[NM-1:0]))
                           || (sampleIrq_q && irqEnable_q[motion_irq_pkg::ST_SAMPLE]);
  assign queueReq = |(queuePend_q & queueCtrl_q[2:0]);

  // routing: default, swapped, or both on one chosen pin
  always_comb
  begin
    if (irqConfig_q[motion_irq_pkg::CFG_COMBINE])
    begin
      reqA = !irqConfig_q[motion_irq_pkg::CFG_COMBINE_PIN] && (sampleMotionReq || queueReq);
      reqB = irqConfig_q[motion_irq_pkg::CFG_COMBINE_PIN] && (sampleMotionReq || queueReq);
    end
    else if (irqConfig_q[motion_irq_pkg::CFG_SWAP])
    begin
      reqA = queueReq;
      reqB = sampleMotionReq;
    end
    else
    begin
      reqA = sampleMotionReq;
      reqB = queueReq;
    end
  end

  assign driveA = pinDrive(reqA, pinCtrl_q[motion_irq_pkg::PIN_A_POLARITY],
                           pinCtrl_q[motion_irq_pkg::PIN_A_DRIVE]);
  assign driveB = pinDrive(reqB, pinCtrl_q[motion_irq_pkg::PIN_B_POLARITY],
                           pinCtrl_q[motion_irq_pkg::PIN_B_DRIVE]);

  // registered pin drive; reset leaves both pins released
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinAOut_q <= 1'b0;
      pinAOe_q <= 1'b0;
      pinBOut_q <= 1'b0;
      pinBOe_q <= 1'b0;
    end
    else
    begin
      pinAOut_q <= driveA[1];
      pinAOe_q <= driveA[0];
      pinBOut_q <= driveB[1];
      pinBOe_q <= driveB[0];
    end
  end

  assign irqPinAOut = pinAOut_q;
  assign irqPinAOe = pinAOe_q;
  assign irqPinBOut = pinBOut_q;
  assign irqPinBOe = pinBOe_q;

  // ----------------
  // register read
  // ----------------
  assign statusView = {sampleFlag_q, 1'b0, |queuePend_q, motionPend_q};

  // read decode; unmapped offsets read zero
  always_comb
  begin
    if ((regAddr == motion_irq_pkg::ADDR_STATUS) || (regAddr == motion_irq_pkg::ADDR_STATUS_ALIAS))
      rdData_d = statusView;
    else if ((regAddr == motion_irq_pkg::ADDR_LIVE_FLAGS) || (regAddr == motion_irq_pkg::ADDR_LIVE_MIRROR))
      rdData_d = {3'h0, motionGated};
    else if (regAddr == motion_irq_pkg::ADDR_IRQ_ENABLE)
      rdData_d = irqEnable_q;
    else if (regAddr == motion_irq_pkg::ADDR_MOTION_CTRL)
      rdData_d = motionCtrl_q;
    else if (regAddr == motion_irq_pkg::ADDR_QUEUE_FLAGS)
      rdData_d = {5'h00, queueFlags_q};
    else if (regAddr == motion_irq_pkg::ADDR_QUEUE_CTRL)
      rdData_d = queueCtrl_q;
    else if (regAddr == motion_irq_pkg::ADDR_QUEUE_THRESH)
      rdData_d = queueThresh_q;
    else if (regAddr == motion_irq_pkg::ADDR_QUEUE_STATUS)
      rdData_d = {5'h00, queuePend_q};
    else if (regAddr == motion_irq_pkg::ADDR_IRQ_CONFIG)
      rdData_d = irqConfig_q;
    else if (regAddr == motion_irq_pkg::ADDR_PIN_CTRL)
      rdData_d = pinCtrl_q;
    else if (regAddr == motion_irq_pkg::ADDR_LATCH_TIMER)
      rdData_d = latchTimer_q;
    else
      rdData_d = 8'h00;
  end

  // read data captured on the read strobe, held until the next read
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdData_q <= 8'h00;
    else if (regRdEn)
      rdData_q <= rdData_d;
  end

  assign regRdData = rdData_q;

endmodule : motion_sensor_interrupt_unit

//--- bench/irq_host_model.sv
`timescale 1ns/1ps
// ----------------
// host side of the two interrupt lines
// ----------------
module irq_host_model (
  input wire logic irqPinAOut,
  input wire logic irqPinAOe,
  input wire logic irqPinBOut,
  input wire logic irqPinBOe,
  output logic lineA,
  output logic lineB
);
  // a released line floats up to its pull-up
  assign lineA = irqPinAOe ? irqPinAOut : 1'b1;
  assign lineB = irqPinBOe ? irqPinBOut : 1'b1;
endmodule : irq_host_model

//--- bench/motion_irq_assertions.sv
`timescale 1ns/1ps
// ----------------
// port checks of the interrupt unit
// ----------------
module motion_irq_assertions #(
  parameter int QUEUE_DEPTH = 32,
  parameter int COUNT_W = 6
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic softwareReset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic sampleDone,
  input wire logic [4:0] motionLive,
  input wire logic [COUNT_W-1:0] queueCount,
  input wire logic irqPinAOut,
  input wire logic irqPinAOe,
  input wire logic irqPinBOut,
  input wire logic irqPinBOe
);
  logic [7:0] pinCtrl_q, cfg_q, thresh_q;
  logic sampleEn_q;

  // shadow of the settings the checks depend on
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n || softwareReset)
      {pinCtrl_q, cfg_q, thresh_q, sampleEn_q} <= {16'h0000, 8'h10, 1'b0};
    else if (regWrEn)
      case (regAddr)
        8'h06: sampleEn_q <= regWrData[7];
        8'h2e: thresh_q <= regWrData;
        8'h31: cfg_q <= regWrData;
        8'h33: pinCtrl_q <= regWrData;
        default: ;
      endcase

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence quiet_s;
    !sampleDone && !regWrEn && $stable(motionLive) && $stable(queueCount);
  endsequence
  sequence clear_s;
    regWrEn && (regAddr == 8'h14 || regAddr == 8'h04) && !cfg_q[6] && pinCtrl_q == 8'h00
      && !sampleDone && $stable(motionLive) && $stable(queueCount);
  endsequence
  sequence hit_s;
    sampleDone && sampleEn_q && cfg_q[5:0] == 6'h00 && pinCtrl_q == 8'h00 && !regWrEn && !softwareReset
      ##1 !regWrEn && !softwareReset;
  endsequence
  sequence stRead_s;
    regRdEn && regAddr == 8'h14 && !sampleDone && !softwareReset;
  endsequence

  globalClear_a: assert property (quiet_s [*2] ##1 clear_s ##1 quiet_s [*2]
    |-> !irqPinAOe && !irqPinBOe) else $error("pin driven after clear");
  sampleIrq_a: assert property (hit_s |=> irqPinAOe && !irqPinAOut) else $error("no sample irq");
  sampleSet_a: assert property (sampleDone && !softwareReset ##1 stRead_s |=> regRdData[7])
    else $error("sample flag not set");
  sampleClear_a: assert property (stRead_s ##1 stRead_s |=> !regRdData[7])
    else $error("sample flag not cleared");
  spareBit_a: assert property (regRdEn && regAddr == 8'h14 |=> !regRdData[6]) else $error("bit 6 set");
  queueFlags_a: assert property (regRdEn && regAddr == 8'h0a && $stable(queueCount) && $past(arst_n)
    && !$past(regWrEn) && !softwareReset && !$past(softwareReset) |=> regRdData[2:0] ==
    {$past(queueCount) >= $past(thresh_q), $past(queueCount) == QUEUE_DEPTH, $past(queueCount) == 0})
    else $error("queue flags wrong");
  pinAPush_a: assert property (pinCtrl_q[2] |=> irqPinAOe) else $error("pin a undriven");
  pinAOpen_a: assert property (!pinCtrl_q[2] |=> !irqPinAOut) else $error("pin a high");
  pinBOpen_a: assert property (!pinCtrl_q[6] |=> !irqPinBOut) else $error("pin b high");
endmodule : motion_irq_assertions

bind motion_sensor_interrupt_unit motion_irq_assertions #(.QUEUE_DEPTH(QUEUE_DEPTH), .COUNT_W(COUNT_W))
  u_motion_irq_assertions (.core_clk(core_clk), .arst_n(arst_n), .softwareReset(softwareReset),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .sampleDone(sampleDone), .motionLive(motionLive), .queueCount(queueCount), .irqPinAOut(irqPinAOut),
  .irqPinAOe(irqPinAOe), .irqPinBOut(irqPinBOut), .irqPinBOe(irqPinBOe));

//--- bench/test_motion_sensor_interrupt_unit.sv
`timescale 1ns/1ps
// ----------------
// bench of the motion sensor interrupt unit
// ----------------
module test_motion_sensor_interrupt_unit;
  logic core_clk, arst_n, softwareReset, zAccumStart, regWrEn, regRdEn, sampleDone;
  logic irqPinAOut, irqPinAOe, irqPinBOut, irqPinBOe, lineA, lineB;
  logic [7:0] regAddr, regWrData, regRdData, d1, d2, thr;
  logic [5:0] queueCount, cnt;
  logic [4:0] motionLive;
  int seed, fails, numChecks, cycles;

  motion_sensor_interrupt_unit #(.UNIT_CYCLES(4)) u_motion_sensor_interrupt_unit (.core_clk(core_clk),
    .arst_n(arst_n), .softwareReset(softwareReset), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .sampleDone(sampleDone), .zAccumStart(zAccumStart),
    .motionLive(motionLive), .queueCount(queueCount), .irqPinAOut(irqPinAOut), .irqPinAOe(irqPinAOe),
    .irqPinBOut(irqPinBOut), .irqPinBOe(irqPinBOe));
  irq_host_model u_irq_host_model (.irqPinAOut(irqPinAOut), .irqPinAOe(irqPinAOe), .irqPinBOut(irqPinBOut),
    .irqPinBOe(irqPinBOe), .lineA(lineA), .lineB(lineB));

  task print_verdict;
    $display("checks %0d fails %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task checkReg(input string what, input logic [7:0] exp, input logic [7:0] got);
    numChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : checkReg

  task checkPin(input string what, input logic exp, input logic got);
    numChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : checkPin

  task writeReg(input logic [7:0] a, input logic [7:0] v);
    regAddr = a;
    regWrData = v;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
    @(negedge core_clk);
  endtask : writeReg

  // two reads back to back, both answers kept
  task readPair(input logic [7:0] a);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    d1 = regRdData;
    @(negedge core_clk);
    d2 = regRdData;
    regRdEn = 1'b0;
    @(negedge core_clk);
  endtask : readPair

  function automatic logic [7:0] queueFlags(input logic [5:0] c, input logic [7:0] t);
    return {5'h00, c >= t, c == 6'h20, c == 6'h00};
  endfunction : queueFlags

  // clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      print_verdict();
    end
  end

  // main sequence
  initial
  begin
    seed = 23488;
    {arst_n, softwareReset, zAccumStart, regWrEn, regRdEn, sampleDone} = 6'h00;
    {regAddr, regWrData, motionLive, queueCount} = 27'h000_0000;
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    readPair(8'h0a);
    checkReg("qflags", 8'h01, d1);
    readPair(8'h2e);
    checkReg("thresh", 8'h10, d1);
    writeReg(8'h06, 8'h80);
    sampleDone = 1'b1;
    @(negedge core_clk);
    sampleDone = 1'b0;
    @(negedge core_clk);
    checkPin("pin a", 1'b0, lineA);
    readPair(8'h14);
    checkReg("status", 8'h80, d1);
    checkReg("status2", 8'h00, d2);
    checkPin("pin a held", 1'b0, lineA);
    writeReg(8'h14, 8'({$random(seed)}));
    checkPin("pin a clear", 1'b1, lineA);
    @(negedge core_clk);
    writeReg(8'h06, 8'h18);
    sampleDone = 1'b1;
    @(negedge core_clk);
    sampleDone = 1'b0;
    readPair(8'h14);
    checkReg("flag only", 8'h80, d1);
    checkPin("pin a idle", 1'b1, lineA);
    writeReg(8'h09, 8'h18);
    motionLive = 5'h1c;
    readPair(8'h03);
    checkReg("live", 8'h00, d1);
    writeReg(8'h09, 8'h1c);
    readPair(8'h03);
    checkReg("live2", 8'h1c, d1);
    readPair(8'h14);
    checkReg("motion", 8'h18, d1);
    writeReg(8'h14, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      cnt = (i == 0) ? 6'h20 : 6'({$random(seed)} % 33);
      thr = (i == 0) ? 8'h20 : 8'({$random(seed)} % 34);
      writeReg(8'h2e, thr);
      queueCount = cnt;
      @(negedge core_clk);
      readPair(8'h0a);
      checkReg("qflags", queueFlags(cnt, thr), d1);
    end
    queueCount = 6'h00;
    writeReg(8'h2e, 8'h10);
    writeReg(8'h2d, 8'h27);
    queueCount = 6'h20;
    repeat (3) @(negedge core_clk);
    readPair(8'h2f);
    checkReg("qpend", 8'h07, d1);
    checkPin("pin b", 1'b0, lineB);
    writeReg(8'h31, 8'h42);
    queueCount = 6'h05;
    writeReg(8'h04, 8'hff);
    writeReg(8'h14, 8'h00);
    readPair(8'h2f);
    checkReg("qkept", 8'h07, d1);
    writeReg(8'h14, 8'h20);
    checkPin("pin b clear", 1'b1, lineB);
    writeReg(8'h06, 8'h84);
    motionLive = 5'h00;
    @(negedge core_clk);
    {motionLive, sampleDone} = 6'h09;
    @(negedge core_clk);
    sampleDone = 1'b0;
    @(negedge core_clk);
    checkPin("auto set", 1'b0, lineA);
    {motionLive, zAccumStart} = 6'h01;
    @(negedge core_clk);
    zAccumStart = 1'b0;
    @(negedge core_clk);
    checkPin("auto clear", 1'b1, lineA);
    writeReg(8'h4a, 8'h01);
    writeReg(8'h31, 8'h01);
    sampleDone = 1'b1;
    @(negedge core_clk);
    sampleDone = 1'b0;
    repeat (8) @(negedge core_clk);
    checkPin("timed held", 1'b0, lineA);
    repeat (2) @(negedge core_clk);
    checkPin("timed clear", 1'b1, lineA);
    writeReg(8'h31, 8'h00);
    writeReg(8'h33, 8'hcc);
    checkPin("pin a idle pp", 1'b0, lineA);
    softwareReset = 1'b1;
    @(negedge core_clk);
    softwareReset = 1'b0;
    readPair(8'h0a);
    checkReg("qflags swrst", 8'h01, d1);
    checkReg("qflags live", queueFlags(queueCount, 8'h10), d2);
    checkPin("pin a swrst", 1'b1, lineA);
    print_verdict();
  end
endmodule : test_motion_sensor_interrupt_unit
